// ### delay_timer_pkg.sv
// Purpose: shared constants and types for the on/off and latching timers
// Assumes: 100 MHz system clock, 16-bit register port
// Notes: offsets are byte addresses on the plain register port
package delay_timer_pkg;
   localparam int unsigned CLK_PERIOD_NS = 10;
   // one millisecond base tick, in ns
   localparam int unsigned TICK_MS_NS = 1000000;
   localparam int unsigned MS_CYCLES_DEF = TICK_MS_NS / CLK_PERIOD_NS;
   localparam int unsigned CYC_W_DEF = 17;

   localparam int DELAY_W = 16;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 16;
   localparam int MSU_W = 22;

   // milliseconds per unit of each selectable time unit
   localparam logic [21:0] MS_PER_MS = 22'h000001;
   localparam logic [21:0] MS_PER_SEC = 22'h0003e8;
   localparam logic [21:0] MS_PER_MIN = 22'h00ea60;
   localparam logic [21:0] MS_PER_HOUR = 22'h36ee80;

   localparam logic [4:0] ON_DELAY_OFS = 5'h00;
   localparam logic [4:0] OFF_DELAY_OFS = 5'h04;
   localparam logic [4:0] LATCH_DELAY_OFS = 5'h08;
   localparam logic [4:0] UNIT_OFS = 5'h0c;
   localparam logic [4:0] STATUS_OFS = 5'h10;

   localparam logic [15:0] DELAY_RST = 16'h0000;
   localparam logic [1:0] UNIT_RST = 2'h0;

   localparam int UNIT_ONOFF_LSB = 0;
   localparam int UNIT_LATCH_LSB = 2;
   localparam int STAT_ONOFF_OUT = 0;
   localparam int STAT_LATCH_OUT = 1;
   localparam int STAT_ONOFF_RUN = 2;
   localparam int STAT_LATCH_RUN = 3;

   typedef enum logic [1:0] {UNIT_MS, UNIT_SEC, UNIT_MIN, UNIT_HOUR}
      time_unit_t;

   typedef struct packed {
      logic [15:0] delay;
      time_unit_t unit;
   } timer_cfg_t;
endpackage

// ### onoff_latch_timers.sv
// Purpose: on/off delay filter and latching on-delay timer
// Assumes: trigger, reset and delay inputs come from logic on sys_clk_i
// Notes: each timer restarts its own millisecond prescaler on every
//        level change, so a delay of N units is exact to one clock
`timescale 1ns/100ps

module onoff_latch_timers
   import delay_timer_pkg::*;
#(
   parameter int unsigned MS_CYCLES = MS_CYCLES_DEF,
   parameter int CYC_W = CYC_W_DEF
) (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   input wire logic [ADDR_W-1:0] reg_addr_i,
   input wire logic [DATA_W-1:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [DATA_W-1:0] reg_rdata_o,
   input wire logic trig_i,
   input wire logic [DELAY_W-1:0] on_delay_value_in_i,
   input wire logic on_delay_conn_i,
   input wire logic [DELAY_W-1:0] off_delay_value_in_i,
   input wire logic off_delay_conn_i,
   input wire logic latch_trig_i,
   input wire logic latch_rst_i,
   input wire logic [DELAY_W-1:0] latch_delay_value_in_i,
   input wire logic latch_delay_conn_i,
   output logic onoff_delay_out_o,
   output logic latching_delay_out_o
);

   logic rst_meta_reg;
   logic rst_n;

   logic [DELAY_W-1:0] on_delay_setting_reg;
   logic [DELAY_W-1:0] off_delay_setting_reg;
   logic [DELAY_W-1:0] latch_delay_setting_reg;
   time_unit_t onoff_unit_reg;
   time_unit_t latch_unit_reg;
   logic [DATA_W-1:0] rdata_reg;
   logic [DATA_W-1:0] rdata_next;

   logic onoff_out_reg;
   logic latch_out_reg;
   logic latch_out_next;
   logic latch_rst_prev_reg;

   timer_cfg_t cfg [2];
   logic run [2];
   logic expire [2];
   logic [CYC_W-1:0] cyc_cnt [2];
   logic [MSU_W-1:0] ms_cnt [2];
   logic [MSU_W-1:0] ms_per_unit [2];
   logic [DELAY_W-1:0] unit_cnt [2];

   // reset release through two flops, assert stays asynchronous
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rst_meta_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n <= rst_meta_reg;
      end
   end

   // register port decode
   wire wr_on = reg_wr_i && (reg_addr_i == ON_DELAY_OFS);
   wire wr_off = reg_wr_i && (reg_addr_i == OFF_DELAY_OFS);
   wire wr_latch = reg_wr_i && (reg_addr_i == LATCH_DELAY_OFS);
   wire wr_unit = reg_wr_i && (reg_addr_i == UNIT_OFS);
   wire [1:0] wdata_onoff_unit = reg_wdata_i[UNIT_ONOFF_LSB +: 2];
   wire [1:0] wdata_latch_unit = reg_wdata_i[UNIT_LATCH_LSB +: 2];

   wire [DATA_W-1:0] unit_word =
      DATA_W'({latch_unit_reg, onoff_unit_reg});
   wire [DATA_W-1:0] status_word =
      DATA_W'({run[1], run[0], latch_out_reg, onoff_out_reg});
   wire [DATA_W-1:0] read_mux =
      (reg_addr_i == ON_DELAY_OFS) ? on_delay_setting_reg :
      (reg_addr_i == OFF_DELAY_OFS) ? off_delay_setting_reg :
      (reg_addr_i == LATCH_DELAY_OFS) ? latch_delay_setting_reg :
      (reg_addr_i == UNIT_OFS) ? unit_word :
      (reg_addr_i == STATUS_OFS) ? status_word : '0;
   assign rdata_next = reg_rd_i ? read_mux : '0;

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         on_delay_setting_reg <= DELAY_RST;
         off_delay_setting_reg <= DELAY_RST;
         latch_delay_setting_reg <= DELAY_RST;
         onoff_unit_reg <= time_unit_t'(UNIT_RST);
         latch_unit_reg <= time_unit_t'(UNIT_RST);
         rdata_reg <= '0;
      end else if (ce_i) begin
         if (wr_on) begin
            on_delay_setting_reg <= reg_wdata_i;
         end
         if (wr_off) begin
            off_delay_setting_reg <= reg_wdata_i;
         end
         if (wr_latch) begin
            latch_delay_setting_reg <= reg_wdata_i;
         end
         if (wr_unit) begin
            onoff_unit_reg <= time_unit_t'(wdata_onoff_unit);
            latch_unit_reg <= time_unit_t'(wdata_latch_unit);
         end
         rdata_reg <= rdata_next;
      end
   end
   assign reg_rdata_o = rdata_reg;

   wire [DELAY_W-1:0] eff_on =
      on_delay_conn_i ? on_delay_value_in_i : on_delay_setting_reg;
   wire [DELAY_W-1:0] eff_off =
      off_delay_conn_i ? off_delay_value_in_i : off_delay_setting_reg;
   wire [DELAY_W-1:0] eff_latch =
      latch_delay_conn_i ? latch_delay_value_in_i : latch_delay_setting_reg;

   assign cfg[0].unit = onoff_unit_reg;
   assign cfg[0].delay = onoff_out_reg ? eff_off : eff_on;
   assign cfg[1].unit = latch_unit_reg;
   assign cfg[1].delay = eff_latch;

   wire rst_edge = latch_rst_i && !latch_rst_prev_reg;

   // run only while trigger differs from output
   assign run[0] = trig_i != onoff_out_reg;
   // drop or reset edge clears count
   assign run[1] = latch_trig_i && !latch_out_reg && !rst_edge;

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_chan
         logic [CYC_W-1:0] cyc_reg;
         logic [MSU_W-1:0] ms_reg;
         logic [DELAY_W-1:0] unit_reg;

         assign ms_per_unit[g] =
            (cfg[g].unit == UNIT_MS) ? MS_PER_MS :
            (cfg[g].unit == UNIT_SEC) ? MS_PER_SEC :
            (cfg[g].unit == UNIT_MIN) ? MS_PER_MIN : MS_PER_HOUR;
         assign expire[g] = run[g] && (unit_reg == cfg[g].delay);

         wire cyc_wrap = cyc_reg == CYC_W'(MS_CYCLES - 1);
         wire ms_wrap = ms_reg >= (ms_per_unit[g] - MSU_W'(1));

         // elapsed time in ticks of the unit
         always_ff @(posedge sys_clk_i or negedge rst_n) begin
            if (!rst_n) begin
               cyc_reg <= '0;
               ms_reg <= '0;
               unit_reg <= '0;
            end else if (ce_i) begin
               if (!run[g] || expire[g]) begin
                  cyc_reg <= '0;
                  ms_reg <= '0;
                  unit_reg <= '0;
               end else if (!cyc_wrap) begin
                  cyc_reg <= cyc_reg + 1'b1;
               end else begin
                  cyc_reg <= '0;
                  if (!ms_wrap) begin
                     ms_reg <= ms_reg + 1'b1;
                  end else begin
                     ms_reg <= '0;
                     unit_reg <= unit_reg + 1'b1;
                  end
               end
            end
         end

         // counters visible to the assertion checks, not to status
         assign cyc_cnt[g] = cyc_reg;
         assign ms_cnt[g] = ms_reg;
         assign unit_cnt[g] = unit_reg;
      end
   endgenerate

   // reset edge wins over a set
   assign latch_out_next = rst_edge ? 1'b0 :
      (expire[1] ? 1'b1 : latch_out_reg);

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         onoff_out_reg <= 1'b0;
         latch_out_reg <= 1'b0;
         latch_rst_prev_reg <= 1'b0;
      end else if (ce_i) begin
         if (expire[0]) begin
            onoff_out_reg <= trig_i;
         end
         latch_out_reg <= latch_out_next;
         latch_rst_prev_reg <= latch_rst_i;
      end
   end

   assign onoff_delay_out_o = onoff_out_reg;
   assign latching_delay_out_o = latch_out_reg;

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_n);

   AST_ONOFF_RISE: assert property (
      $rose(onoff_delay_out_o) |-> ($past(ce_i) && $past(trig_i) &&
         $past(unit_cnt[0]) == $past(eff_on)))
      else $error("on/off output rose before on-delay elapsed");

   AST_ONOFF_FALL: assert property (
      $fell(onoff_delay_out_o) |-> ($past(ce_i) && !$past(trig_i) &&
         $past(unit_cnt[0]) == $past(eff_off)))
      else $error("on/off output fell before off-delay elapsed");

   AST_ONOFF_RESTART: assert property (
      (ce_i && trig_i == onoff_delay_out_o) |=>
         (unit_cnt[0] == '0 && cyc_cnt[0] == '0 && $stable(onoff_out_reg)))
      else $error("on/off timing not restarted on level match");

   AST_ON_PORT_SRC: assert property (
      (on_delay_conn_i && !onoff_out_reg) |->
         cfg[0].delay == on_delay_value_in_i)
      else $error("connected on-delay port not used");

   AST_MS_TICK: assert property (
      (ce_i && run[0] && !expire[0] && cyc_cnt[0] == CYC_W'(MS_CYCLES - 1))
         |=> (cyc_cnt[0] == '0))
      else $error("millisecond prescaler did not wrap");

   AST_LATCH_SET: assert property (
      $rose(latching_delay_out_o) |-> ($past(ce_i) &&
         $past(latch_trig_i) && $past(unit_cnt[1]) == $past(eff_latch)))
      else $error("latching output set before delay elapsed");

   AST_LATCH_HOLD: assert property (
      (latching_delay_out_o && !(ce_i && rst_edge)) |=>
         latching_delay_out_o)
      else $error("latched output dropped without reset edge");

   AST_LATCH_CLEAR: assert property (
      (ce_i && $rose(latch_rst_i)) |=>
         (!latching_delay_out_o && unit_cnt[1] == '0 && cyc_cnt[1] == '0))
      else $error("reset edge did not clear latching timer");

   AST_LATCH_ABANDON: assert property (
      (ce_i && !latch_trig_i) ##1 (ce_i && latch_trig_i) |->
         (unit_cnt[1] == '0 && cyc_cnt[1] == '0))
      else $error("partial latching count kept after trigger drop");

   AST_FREEZE: assert property (
      !ce_i |=> ($stable(onoff_out_reg) && $stable(latch_out_reg)))
      else $error("state moved while clock enable low");

   AST_FREEZE_CFG: assert property (
      !ce_i |=> ($stable(on_delay_setting_reg) && $stable(unit_cnt[0])
         && $stable(unit_cnt[1])))
      else $error("settings or counters moved while clock enable low");

   AST_OFF_PORT_SRC: assert property (
      (off_delay_conn_i && onoff_out_reg) |->
         cfg[0].delay == off_delay_value_in_i)
      else $error("connected off-delay port not used");

   AST_ON_STORED_SRC: assert property (
      (!on_delay_conn_i && !onoff_out_reg) |->
         cfg[0].delay == on_delay_setting_reg)
      else $error("stored on-delay not used");

   AST_OFF_STORED_SRC: assert property (
      (!off_delay_conn_i && onoff_out_reg) |->
         cfg[0].delay == off_delay_setting_reg)
      else $error("stored off-delay not used");

   AST_LATCH_PORT_SRC: assert property (
      latch_delay_conn_i |-> cfg[1].delay == latch_delay_value_in_i)
      else $error("connected latching delay port not used");

   AST_LATCH_STORED_SRC: assert property (
      !latch_delay_conn_i |-> cfg[1].delay == latch_delay_setting_reg)
      else $error("stored latching delay not used");

   AST_UNIT_STEP: assert property (
      (ce_i && run[0] && !expire[0] && cyc_cnt[0] != CYC_W'(MS_CYCLES - 1))
         |=> $stable(unit_cnt[0]))
      else $error("unit count moved between millisecond ticks");

   AST_SEC_TICK: assert property (
      (ce_i && run[0] && !expire[0] && cfg[0].unit == UNIT_SEC &&
         cyc_cnt[0] == CYC_W'(MS_CYCLES - 1) &&
         ms_cnt[0] == MS_PER_SEC - 22'h000001) |=>
         (ms_cnt[0] == '0 && unit_cnt[0] == $past(unit_cnt[0]) + 1'b1))
      else $error("second not counted after its milliseconds");

   AST_ONOFF_FILTER: assert property (
      (ce_i && !expire[0]) |=> $stable(onoff_delay_out_o))
      else $error("on/off output moved without an expired delay");

   AST_LATCH_NO_EARLY: assert property (
      (ce_i && !latch_trig_i && !latching_delay_out_o) |=>
         !latching_delay_out_o)
      else $error("latching output set with trigger low");

   AST_RDATA_IDLE: assert property (
      (ce_i && !reg_rd_i) |=> reg_rdata_o == '0)
      else $error("read data not cleared after read cycle");

   AST_RDATA_ON: assert property (
      (ce_i && reg_rd_i && reg_addr_i == ON_DELAY_OFS) |=>
         reg_rdata_o == $past(on_delay_setting_reg))
      else $error("stored on-delay not returned on read");

   AST_STATUS_RUN: assert property (
      (ce_i && reg_rd_i && reg_addr_i == STATUS_OFS) |=>
         reg_rdata_o[STAT_ONOFF_RUN] == ($past(trig_i) != $past(onoff_out_reg)))
      else $error("status counting bit wrong");

   COV_ONOFF_RISE: cover property ($rose(onoff_delay_out_o));
   COV_ONOFF_FALL: cover property ($fell(onoff_delay_out_o));
   COV_LATCH_SET: cover property ($rose(latching_delay_out_o));
   COV_FREEZE: cover property (!ce_i && trig_i != onoff_out_reg);
   COV_LATCH_RST: cover property (
      latching_delay_out_o ##1 !latching_delay_out_o);
endmodule

// ### delay_source.sv
// Purpose: upstream logic that feeds delay values to the timers
// Assumes: requests may be wider than the timer accepts
// Notes: combinational, no added latency
`timescale 1ns/100ps
module delay_source
   import delay_timer_pkg::*;
(
   input wire logic [31:0] on_req_i,
   input wire logic [31:0] off_req_i,
   input wire logic [31:0] latch_req_i,
   output logic [DELAY_W-1:0] on_val_o,
   output logic [DELAY_W-1:0] off_val_o,
   output logic [DELAY_W-1:0] latch_val_o
);
   function automatic logic [DELAY_W-1:0] sat(input logic [31:0] v);
      return (v > 32'h0000ffff) ? 16'hffff : v[DELAY_W-1:0];
   endfunction
   assign on_val_o = sat(on_req_i);
   assign off_val_o = sat(off_req_i);
   assign latch_val_o = sat(latch_req_i);
endmodule

// ### test_on_off_and_latching_delay_timers.sv
// Purpose: self-checking bench for the on/off and latching timers
// Assumes: MS_CYCLES of 4, so one ms is four clocks
// Notes: edge checks allow a window of three clocks
`timescale 1ns/100ps
module test_on_off_and_latching_delay_timers;
   import delay_timer_pkg::*;
   logic sys_clk = '0, nrst = '0, ce = '1, wr = '0, rd = '0;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wdata = '0, rdata;
   logic trig = '0, ltrig = '0, lrst = '0, on_c = '0, off_c = '0, l_c = '0;
   logic [31:0] on_r = '0, off_r = '0, l_r = '0;
   logic [DELAY_W-1:0] on_v, off_v, l_v;
   logic q_oo, q_l;
   int error_cnt = 0, n_compared = 0;

   always #5 sys_clk = ~sys_clk;

   delay_source u_src (.on_req_i(on_r), .off_req_i(off_r),
      .latch_req_i(l_r), .on_val_o(on_v), .off_val_o(off_v),
      .latch_val_o(l_v));

   onoff_latch_timers #(.MS_CYCLES(4)) uut (.sys_clk_i(sys_clk),
      .nrst_i(nrst), .ce_i(ce), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .trig_i(trig),
      .on_delay_value_in_i(on_v), .on_delay_conn_i(on_c),
      .off_delay_value_in_i(off_v), .off_delay_conn_i(off_c),
      .latch_trig_i(ltrig), .latch_rst_i(lrst),
      .latch_delay_value_in_i(l_v), .latch_delay_conn_i(l_c),
      .onoff_delay_out_o(q_oo), .latching_delay_out_o(q_l));

   task automatic summarize;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         $display("Error %0t: got %h expected %h", $time, got, exp);
         error_cnt++;
      end
   endtask

   function automatic logic pick(input bit s);
      return s ? q_l : q_oo;
   endfunction

   task automatic wreg(input logic [4:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      wr <= '1;
      addr <= a;
      wdata <= d;
      @(posedge sys_clk);
      wr <= '0;
   endtask

   task automatic rreg(input logic [4:0] a, input logic [15:0] e);
      @(posedge sys_clk);
      rd <= '1;
      addr <= a;
      @(posedge sys_clk);
      rd <= '0;
      #1 cmp(rdata, e);
   endtask

   // old level until n-1 clocks, new level by n+2
   task automatic span(input bit s, input int n, input logic v);
      repeat (n - 1) @(posedge sys_clk);
      #1 cmp(pick(s), !v);
      repeat (3) @(posedge sys_clk);
      #1 cmp(pick(s), v);
   endtask

   task automatic hold(input bit s, input int n, input logic v);
      repeat (n) begin
         @(posedge sys_clk);
         #1 cmp(pick(s), v);
      end
   endtask

   initial begin
      #400000;
      error_cnt++;
      $display("Error %0t: watchdog expired", $time);
      summarize();
   end

   initial begin
      repeat (6) @(posedge sys_clk);
      nrst <= '1;
      repeat (3) @(posedge sys_clk);
      hold(0, 1, '0);
      hold(1, 1, '0);
      rreg(ON_DELAY_OFS, 16'h0000);
      rreg(UNIT_OFS, 16'h0000);
      wreg(ON_DELAY_OFS, 16'h0002);
      wreg(OFF_DELAY_OFS, 16'h0003);
      wreg(LATCH_DELAY_OFS, 16'h0002);
      rreg(OFF_DELAY_OFS, 16'h0003);
      wreg(STATUS_OFS, 16'hffff);
      rreg(STATUS_OFS, 16'h0000);
      rreg(5'h14, 16'h0000);
      $display("registers done");
      @(posedge sys_clk);
      trig <= '1;
      span(0, 8, '1);
      @(posedge sys_clk);
      trig <= '0;
      span(0, 12, '0);
      @(posedge sys_clk);
      trig <= '1;
      repeat (5) @(posedge sys_clk);
      trig <= '0;
      hold(0, 20, '0);
      @(posedge sys_clk);
      on_c <= '1;
      on_r <= 32'h00010000;
      trig <= '1;
      hold(0, 30, '0);
      rreg(STATUS_OFS, 16'h0004);
      @(posedge sys_clk);
      trig <= '0;
      on_r <= 32'h00000001;
      hold(0, 2, '0);
      @(posedge sys_clk);
      ce <= '0;
      trig <= '1;
      hold(0, 10, '0);
      @(posedge sys_clk);
      ce <= '1;
      @(posedge sys_clk);
      trig <= '1;
      span(0, 4, '1);
      @(posedge sys_clk);
      off_c <= '1;
      off_r <= 32'h00000002;
      trig <= '0;
      span(0, 8, '0);
      $display("on/off ms done");
      wreg(UNIT_OFS, 16'h0001);
      rreg(UNIT_OFS, 16'h0001);
      @(posedge sys_clk);
      trig <= '1;
      span(0, 4000, '1);
      @(posedge sys_clk);
      off_r <= 32'h00000001;
      trig <= '0;
      span(0, 4000, '0);
      for (int u = 2; u < 4; u++) begin
         wreg(UNIT_OFS, 16'(u));
         @(posedge sys_clk);
         trig <= '1;
         hold(0, 4010, '0);
         @(posedge sys_clk);
         trig <= '0;
         hold(0, 2, '0);
      end
      $display("units done");
      wreg(UNIT_OFS, 16'h0000);
      @(posedge sys_clk);
      ltrig <= '1;
      span(1, 8, '1);
      @(posedge sys_clk);
      ltrig <= '0;
      hold(1, 20, '1);
      rreg(STATUS_OFS, 16'h0002);
      @(posedge sys_clk);
      ltrig <= '1;
      hold(1, 3, '1);
      @(posedge sys_clk);
      lrst <= '1;
      span(1, 1, '0);
      hold(1, 4, '0);
      @(posedge sys_clk);
      lrst <= '0;
      ltrig <= '0;
      hold(1, 5, '0);
      @(posedge sys_clk);
      ltrig <= '1;
      repeat (5) @(posedge sys_clk);
      ltrig <= '0;
      hold(1, 10, '0);
      @(posedge sys_clk);
      ltrig <= '1;
      span(1, 8, '1);
      @(posedge sys_clk);
      lrst <= '1;
      ltrig <= '0;
      l_c <= '1;
      l_r <= 32'h00000001;
      hold(1, 3, '0);
      @(posedge sys_clk);
      lrst <= '0;
      ltrig <= '1;
      span(1, 4, '1);
      wreg(UNIT_OFS, 16'h0004);
      rreg(UNIT_OFS, 16'h0004);
      @(posedge sys_clk);
      lrst <= '1;
      ltrig <= '0;
      hold(1, 2, '0);
      @(posedge sys_clk);
      lrst <= '0;
      ltrig <= '1;
      span(1, 4000, '1);
      $display("latching done");
      @(posedge sys_clk);
      nrst <= '0;
      #2 cmp(q_l, '0);
      $display("reset done");
      summarize();
   end
endmodule
